// ===== hdl/empx_pkg.sv
// Package of constants and carrier types for the external memory pin sharing block
package empx_pkg;
	localparam int ADDR_W      = 25;
	localparam int CORE_ADDR_W = 26;
	localparam int BOOT_W      = 4;
	localparam int LANES       = 4;
	localparam int RC_W        = 12;
	localparam int CS_W        = 6;
	// ************************************************
	// Bank and row/column address fields
	// ************************************************
	localparam int LIN_PIN_LO  = 11;
	localparam int LIN_CORE_LO = 21;
	localparam int LIN_W       = 5;
	localparam int ILV_PIN_LO  = 16;
	localparam int ILV_CORE_LO = 9;
	localparam int ILV_W       = 4;
	localparam int RC_PIN_LO   = 1;
	localparam int RC_LOW_W    = 10;
	// ************************************************
	// Reset values and timing
	// ************************************************
	localparam logic       FMUX_SDRAM_RST = 1'b1;
	localparam logic [3:0] BOOT_RST       = 4'h0;
	localparam int         BCLK_DIV       = 2;
	localparam int         FIRST_WAIT_LONG  = 4;
	localparam int         FIRST_WAIT_SHORT = 1;
	localparam int         BURST_MAX      = 8;

	typedef enum logic [1:0] {
		EMPX_IDLE,
		EMPX_LATCH,
		EMPX_WAIT,
		EMPX_BEAT
	} empx_state_t;

	typedef struct packed {
		logic                   valid;
		logic                   write;
		logic                   burst;
		logic                   sdram;
		logic                   interleave;
		logic [LANES-1:0]       laneEn;
		logic [CORE_ADDR_W-1:0] addr;
		logic [1:0]             csSel;
	} empx_req_t;

	typedef struct packed {
		logic [LANES-1:0]  byteStrobeN;
		logic              outEnN;
		logic              readWrite;
		logic              burstAddrLatchN;
		logic              burstClk;
		logic [CS_W-1:0]   chipSelN;
		logic [ADDR_W-1:0] addrPins;
		logic [1:0]        rowColHigh;
	} empx_pins_t;
endpackage

// ===== hdl/empx_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
module empx_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_sys,
	input  wire logic         srst,
	input  wire logic         ce,
	input  wire logic [W-1:0] din,
	input  wire logic [W-1:0] rstVal,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta_q;

	// First stage read only by the second
	always_ff @(posedge clk_sys) begin
		// Reset to the pin's idle level so no false request follows reset
		if (srst) begin
			meta_q <= rstVal;
			dout   <= rstVal;
		end else if (ce) begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule

// ===== hdl/empx_pin_share.sv
// External memory pin sharing: strobes, chip select muxing, burst handshake, boot capture
`timescale 1ns/10ps
module empx_pin_share
	import empx_pkg::*;
#(
	parameter int FIRST_LONG  = FIRST_WAIT_LONG,
	parameter int FIRST_SHORT = FIRST_WAIT_SHORT
) (
	input  wire logic                    clk_sys,
	input  wire logic                    srst,
	input  wire logic                    ce,
	input  wire empx_pkg::empx_req_t     req,
	input  wire logic [3:0]              asyncCsN,
	input  wire logic                    function_mux_control,
	input  wire logic                    burst_restart_request_n,
	input  wire logic [3:0]              bootPins,
	output logic                         reqDone,
	output logic                         burstRestarted,
	output logic [3:0]                   bootMode,
	output empx_pkg::empx_pins_t         pins
);
	import empx_pkg::*;

	// Wait counter is four bits wide
	if (FIRST_LONG < 1 || FIRST_SHORT < 1 || FIRST_LONG < FIRST_SHORT ||
		FIRST_LONG > 15) begin : gBadCounts
		$error("empx_pin_share: bad first access counts");
	end

	// ************************************************
	// Pin input synchronisers
	// ************************************************
	logic [4:0] syncIn;
	empx_sync #(.W(5)) uSync (
		.clk_sys (clk_sys),
		.srst    (srst),
		.ce      (ce),
		.din     ({burst_restart_request_n, bootPins}),
		.rstVal  (5'h10),
		.dout    (syncIn)
	);
	logic restartN;
	logic seenRst_q;
	assign restartN = syncIn[4] | ~seenRst_q;

	// ************************************************
	// Boot capture
	// ************************************************
	// Straps caught on the third clock after release, once synchroniser has filled
	logic [1:0] bootCnt_q;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bootCnt_q <= 2'h0;
			bootMode  <= BOOT_RST;
			seenRst_q <= 1'b0;
		end else if (ce) begin
			if (bootCnt_q != 2'h2) begin
				bootCnt_q <= bootCnt_q + 2'h1;
			end else if (!seenRst_q) begin
				bootMode  <= syncIn[3:0];
				seenRst_q <= 1'b1;
			end
		end
	end

	// ************************************************
	// Burst sequencer
	// ************************************************
	empx_state_t state_q;
	logic [3:0]  waitCnt_q;
	logic [3:0]  beatCnt_q;
	logic        bclk_q;
	logic        restartHit;
	empx_req_t   cur_q;

	// Level sensitive: a restart input held low re-arms the latch each time
	assign restartHit = ~restartN && cur_q.burst && !cur_q.sdram &&
		(state_q == EMPX_WAIT || state_q == EMPX_BEAT);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_q        <= EMPX_IDLE;
			waitCnt_q      <= 4'h0;
			beatCnt_q      <= 4'h0;
			cur_q          <= '0;
			reqDone        <= 1'b0;
			burstRestarted <= 1'b0;
		end else if (ce) begin
			reqDone        <= 1'b0;
			burstRestarted <= 1'b0;
			unique case (state_q)
				EMPX_IDLE: begin
					if (req.valid) begin
						cur_q <= req;
						if (req.burst && !req.sdram) begin
							state_q <= EMPX_LATCH;
						end else begin
							state_q   <= EMPX_WAIT;
							waitCnt_q <= 4'(FIRST_SHORT);
						end
					end
				end
				EMPX_LATCH: begin
					state_q   <= EMPX_WAIT;
					waitCnt_q <= 4'(FIRST_LONG);
					beatCnt_q <= 4'h0;
				end
				EMPX_WAIT: begin
					if (restartHit) begin
						state_q        <= EMPX_LATCH;
						burstRestarted <= 1'b1;
					end else if (waitCnt_q > 4'h1) begin
						waitCnt_q <= waitCnt_q - 4'h1;
					end else if (cur_q.burst && !cur_q.sdram) begin
						state_q <= EMPX_BEAT;
					end else begin
						state_q <= EMPX_IDLE;
						reqDone <= 1'b1;
					end
				end
				EMPX_BEAT: begin
					if (restartHit) begin
						state_q        <= EMPX_LATCH;
						burstRestarted <= 1'b1;
					end else if (bclk_q) begin
						if (beatCnt_q == 4'(BURST_MAX - 1)) begin
							state_q <= EMPX_IDLE;
							reqDone <= 1'b1;
						end
						beatCnt_q <= beatCnt_q + 4'h1;
					end
				end
			endcase
		end
	end

	// Burst clock toggles only in the beat phase
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			bclk_q <= 1'b0;
		end else if (ce) begin
			bclk_q <= (state_q == EMPX_BEAT) ? ~bclk_q : 1'b0;
		end
	end

	// ************************************************
	// Pin drive
	// ************************************************
	logic active;
	assign active = (state_q != EMPX_IDLE);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			pins <= '{byteStrobeN: '1, outEnN: 1'b1, readWrite: 1'b1,
				burstAddrLatchN: 1'b1, burstClk: 1'b0, chipSelN: '1,
				addrPins: '0, rowColHigh: '0};
		end else if (ce) begin
			// Lane 0 of the strobe vector is the top lane, data 31:24
			pins.byteStrobeN <= active ? ~cur_q.laneEn : '1;
			pins.outEnN      <= ~(active && !cur_q.write);
			pins.readWrite   <= ~(active && cur_q.write);
			pins.burstAddrLatchN <= ~(state_q == EMPX_LATCH);
			pins.burstClk    <= bclk_q;
			pins.chipSelN[1:0] <= asyncCsN[1:0];
			pins.chipSelN[5:4] <= asyncCsN[3:2];
			// Reset default picks SDRAM selects; slot 1 then serves boot flash
			if (function_mux_control == FMUX_SDRAM_RST) begin
				pins.chipSelN[2] <= ~(active && cur_q.sdram && cur_q.csSel[0]);
				pins.chipSelN[3] <= ~(active && cur_q.sdram && cur_q.csSel[1]);
			end else begin
				pins.chipSelN[3:2] <= '1;
			end
			pins.addrPins   <= cur_q.addr[ADDR_W-1:0];
			pins.rowColHigh <= '0;
			if (cur_q.sdram) begin
				pins.addrPins[RC_PIN_LO +: RC_LOW_W] <= cur_q.addr[0 +: RC_LOW_W];
				pins.rowColHigh <= cur_q.addr[RC_LOW_W +: 2];
				if (cur_q.interleave) begin
					pins.addrPins[ILV_PIN_LO +: ILV_W] <= cur_q.addr[ILV_CORE_LO +: ILV_W];
				end else begin
					pins.addrPins[LIN_PIN_LO +: LIN_W] <= cur_q.addr[LIN_CORE_LO +: LIN_W];
				end
			end
		end
	end
endmodule

// ===== test/empx_pin_share_asserts.sv
// Port checks for the pin sharing block
`timescale 1ns/10ps
module empx_pin_share_asserts
	import empx_pkg::*;
(
	input wire logic                 clk_sys,
	input wire logic                 srst,
	input wire logic                 function_mux_control,
	input wire logic                 reqDone,
	input wire logic                 burstRestarted,
	input wire logic [3:0]           bootMode,
	input wire empx_pkg::empx_pins_t pins
);
	logic [3:0] upCnt_q;
	// Saturates so the boot check stays armed
	always_ff @(posedge clk_sys) begin
		if (srst)
			upCnt_q <= 4'h0;
		else if (upCnt_q != 4'hF)
			upCnt_q <= upCnt_q + 4'h1;
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (srst);
	rst_idle_a: assert property ($fell(srst) |-> pins.byteStrobeN == 4'hF &&
		pins.outEnN && !pins.burstClk && pins.chipSelN == 6'h3F) else $error("pins not idle");
	oe_read_a: assert property (!pins.outEnN |-> pins.readWrite)
		else $error("output enable on write");
	write_no_oe_a: assert property (!pins.readWrite |-> pins.outEnN)
		else $error("write with output enable");
	mux_off_a: assert property (!function_mux_control [*3] |-> pins.chipSelN[3:2] == 2'h3)
		else $error("shared selects driven");
	restart_latch_a: assert property (burstRestarted |-> ##[1:4] !pins.burstAddrLatchN)
		else $error("no new latch after cut");
	latch_pulse_a: assert property ($fell(pins.burstAddrLatchN) |=> pins.burstAddrLatchN)
		else $error("latch too long");
	bclk_latch_a: assert property (pins.burstClk |-> pins.burstAddrLatchN)
		else $error("clock during latch");
	boot_hold_a: assert property (upCnt_q == 4'hF |-> $stable(bootMode))
		else $error("boot mode moved");
	cover property (burstRestarted);
	cover property ($rose(pins.burstClk));
	cover property (reqDone);
endmodule
bind empx_pin_share empx_pin_share_asserts i_chk (.clk_sys(clk_sys), .srst(srst),
	.function_mux_control(function_mux_control), .reqDone(reqDone),
	.burstRestarted(burstRestarted), .bootMode(bootMode), .pins(pins));

// ===== test/empx_flash_model.sv
// Burst flash and board straps beyond the pins
`timescale 1ns/10ps
module empx_flash_model
	import empx_pkg::*;
#(
	parameter logic [3:0] STRAP = 4'h5
) (
	input  wire logic                 clk_sys,
	input  wire logic                 cutBurst,
	input  wire empx_pkg::empx_pins_t pins,
	output logic                      restartN,
	output logic [3:0]                bootPins
);
	logic prevClk = 1'b0;
	logic cutDone = 1'b0;
	int   lowCnt  = 0;
	assign bootPins = STRAP;
	// One short cut per assertion of cutBurst: the block restarts again while the input stays low
	always @(posedge clk_sys) begin
		prevClk <= pins.burstClk;
		if (!cutBurst)
			cutDone <= 1'b0;
		if (lowCnt > 0)
			lowCnt <= lowCnt - 1;
		else if (cutBurst && !cutDone && pins.burstClk && !prevClk) begin
			lowCnt  <= 1;
			cutDone <= 1'b1;
		end
	end
	assign restartN = (lowCnt == 0);
endmodule

// ===== test/testbench.sv
// Self-checking bench for the pin sharing block
`timescale 1ns/10ps
module testbench;
	import empx_pkg::*;
	logic       clk_sys = 1'b0;
	logic       srst    = 1'b1;
	logic       fmux    = 1'b1;
	logic       cut     = 1'b0;
	logic       ce      = 1'b1;
	logic [3:0] csN     = 4'hF;
	logic       restartN, done, restarted, lastClk;
	logic [3:0] bootPins, bootMode;
	empx_req_t  req = '0;
	empx_pins_t pins, snap;
	int         num_errors = 0;
	int         total_checks = 0;
	int         latchCnt, edges, cuts;
	always #25 clk_sys = ~clk_sys;
	empx_pin_share i_empx_pin_share (.clk_sys(clk_sys), .srst(srst), .ce(ce), .req(req),
		.asyncCsN(csN), .function_mux_control(fmux), .burst_restart_request_n(restartN),
		.bootPins(bootPins), .reqDone(done), .burstRestarted(restarted),
		.bootMode(bootMode), .pins(pins));
	empx_flash_model i_empx_flash_model (.clk_sys(clk_sys), .cutBurst(cut), .pins(pins),
		.restartN(restartN), .bootPins(bootPins));
	task automatic report_and_stop();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH at %0t: got %0h expected %0h", $time, got, exp);
		end
	endtask
	// Burst bookkeeping rides on every cycle
	task automatic tick();
		@(posedge clk_sys);
		#1;
		latchCnt += !pins.burstAddrLatchN;
		edges = !pins.burstAddrLatchN ? 0 : edges + (pins.burstClk && !lastClk);
		cuts += restarted;
		lastClk = pins.burstClk;
	endtask
	task automatic run_req(input empx_req_t r);
		int n;
		{latchCnt, edges, cuts} = '0;
		req = r;
		tick();
		req.valid = 1'b0;
		for (n = 0; n < 200 && done !== 1'b1; n++)
			tick();
		if (n == 200) begin
			num_errors++;
			report_and_stop();
		end
		// Pins stand active in the cycle that shows done
		snap = pins;
		tick();
	endtask
	task automatic t_reset();
		check(bootMode, 4'h5);
		check(pins.chipSelN, 6'h3F);
		// Frozen while enable is low, then the async selects pass through
		ce = 1'b0;
		csN = 4'hA;
		tick();
		tick();
		check(pins.chipSelN, 6'h3F);
		ce = 1'b1;
		tick();
		check(pins.chipSelN, 6'h2E);
		csN = 4'hF;
		tick();
	endtask
	task automatic t_lanes();
		empx_req_t r;
		for (int w = 0; w < 2; w++) begin
			r = '{valid: 1'b1, write: w[0], laneEn: w ? 4'h6 : 4'h9, default: '0};
			run_req(r);
			check(snap.byteStrobeN, 4'(~r.laneEn));
			check(snap.outEnN, r.write);
			check(snap.readWrite, !r.write);
		end
	endtask
	task automatic t_sdram();
		empx_req_t r;
		for (int i = 0; i < 3; i++) begin
			fmux = (i != 2);
			repeat (4) tick();
			r = '{valid: 1'b1, sdram: 1'b1, interleave: i[0], addr: 26'h2B4D3C5,
				csSel: i ? 2'h2 : 2'h1, default: '0};
			run_req(r);
			if (i == 0)
				check(snap.addrPins[15:11], r.addr[25:21]);
			if (i == 1)
				check(snap.addrPins[19:16], r.addr[12:9]);
			check({snap.rowColHigh, snap.addrPins[10:1]}, r.addr[11:0]);
			check(snap.chipSelN[3:2], fmux ? 2'(~r.csSel) : 2'h3);
		end
		fmux = 1'b1;
	endtask
	task automatic t_burst();
		cut = 1'b1;
		run_req('{valid: 1'b1, burst: 1'b1, laneEn: 4'hF, default: '0});
		check(cuts, 1);
		check(latchCnt, 2);
		check(edges, 8);
		cut = 1'b0;
	endtask
	initial begin
		repeat (10) tick();
		srst = 1'b0;
		repeat (6) tick();
		t_reset();
		t_lanes();
		t_sdram();
		t_burst();
		report_and_stop();
	end
endmodule
